// ===== common/sts_pkg.sv
// constants, types and register map for the startup timing sequencer
// assumes a 250 MHz core clock and a PMBus transaction layer on its own link clock
package sts_pkg;

	// command codes
	localparam logic [7:0] CMD_DELAY = 8'h60;
	localparam logic [7:0] CMD_RISE = 8'h61;
	localparam logic [7:0] CMD_TMO_LIMIT = 8'h62;
	localparam logic [7:0] CMD_TMO_ACTION = 8'h63;
	localparam logic [7:0] CMD_CLEAR = 8'h03;
	localparam logic [7:0] CMD_STAT_BYTE = 8'h78;
	localparam logic [7:0] CMD_STAT_WORD = 8'h79;
	localparam logic [7:0] CMD_STAT_VOUT = 8'h7A;
	localparam logic [7:0] CMD_STAT_CML = 8'h7E;

	// linear word fields
	localparam int EXP_HI = 15;
	localparam int EXP_LO = 11;
	localparam int MAN_HI = 10;
	localparam logic [4:0] EXP_QUARTER = 5'h1E;
	localparam logic [4:0] EXP_HALF = 5'h1F;
	localparam logic [4:0] EXP_UNIT = 5'h00;

	// action byte fields
	localparam int ACT_SEL_HI = 7;
	localparam int ACT_SEL_LO = 6;
	localparam int ACT_RTY_HI = 5;
	localparam int ACT_RTY_LO = 3;
	localparam int ACT_WAIT_HI = 2;
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_DELAYED = 2'h1;
	localparam logic [1:0] ACT_IMMEDIATE = 2'h2;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// reset values
	localparam logic [15:0] DELAY_RST = 16'hF800;
	localparam logic [15:0] RISE_RST = 16'hF00C;
	localparam logic [15:0] TMO_LIMIT_RST = 16'hF814;
	localparam logic [7:0] TMO_ACTION_RST = 8'h80;

	// supported ranges in quarter milliseconds
	localparam logic [12:0] DELAY_MAX_Q = 13'h1FE;
	localparam logic [12:0] RISE_MAX_Q = 13'h07F;
	localparam logic [12:0] RISE_MIN_Q = 13'h002;
	localparam logic [12:0] TMO_MAX_Q = 13'h1FC;

	// status bit positions
	localparam int STB_NONE_ABOVE = 0;
	localparam int STW_VOUT = 15;
	localparam int STV_TMO = 2;
	localparam int CML_INVALID = 7;

	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int QUARTER_MS_NS = 250000;
	localparam int INIT_DELAY_NS = 100000;
	localparam int QUARTER_MS_CYCLES = QUARTER_MS_NS / CLK_PERIOD_NS;
	localparam int INIT_CYCLES_MIN = (INIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_INIT = 3'b001,
		ST_DELAY = 3'b010,
		ST_RAMP = 3'b011,
		ST_REGULATE = 3'b100,
		ST_HICCUP = 3'b101,
		ST_LATCHOFF = 3'b110
	} sts_state_type;

	typedef struct packed {
		logic write;
		logic word;
		logic [7:0] cmd;
		logic [15:0] data;
	} sts_lreq_type;

	typedef struct packed {
		logic invalid;
		logic [15:0] rdData;
	} sts_lresp_type;

endpackage

// ===== dv/sts_host_model.sv
// host-side model of the link transaction layer: issues one decoded request at a time
// assumes the block's link contract: one-cycle strobe, busy, then a one-cycle done
module sts_host_model
	import sts_pkg::*;
(
	// link clock and reset
	input wire logic lnkClk,
	input wire logic lnkRst_n,
	// transaction port
	output logic lnkReqValid,
	output sts_lreq_type lnkReq,
	input wire logic lnkBusy_q,
	input wire logic lnkDone_q,
	input wire sts_lresp_type lnkResp_q
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		lnkReqValid = 1'b0;
		lnkReq = '0;
	end

	task automatic xfer(input logic wr, input logic wd, input logic [7:0] cmd,
		input logic [15:0] data, output sts_lresp_type resp, output logic ok);
		int n;
		ok = 1'b0;
		n = 0;
		@(negedge lnkClk);
		while ((lnkBusy_q !== 1'b0 || lnkRst_n !== 1'b1) && n < 20)
		begin
			@(negedge lnkClk);
			n++;
		end
		lnkReq = '{wr, wd, cmd, data};
		lnkReqValid = 1'b1;
		@(posedge lnkClk);
		@(negedge lnkClk);
		lnkReqValid = 1'b0;
		// released lines must not keep showing the old request
		lnkReq = ~lnkReq;
		n = 0;
		while (lnkDone_q !== 1'b1 && n < 8)
		begin
			@(negedge lnkClk);
			n++;
		end
		resp = lnkResp_q;
		ok = (lnkDone_q === 1'b1);
	endtask
endmodule

// ===== dv/tb_sts_sequencer.sv
// self-checking bench for the startup timing sequencer
// assumes shortened quarter-millisecond and init counts; link clock 64 ns, core 4 ns
module tb_sts_sequencer
	import sts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int QC = 16;
	localparam int IC = 8;

	typedef struct packed {
		logic wr;
		logic wd;
		logic [7:0] cmd;
		logic [15:0] data;
		logic inv;
		logic [15:0] rd;
	} sts_tbrow_type;

	logic mclk, rst_n, lnkClk, lnkRst_n, lnkReqValid, lnkBusy_q, lnkDone_q;
	sts_lreq_type lnkReq;
	sts_lresp_type lnkResp_q;
	logic startIn, above85In, outputEnable_q, rampActive_q, uvCheckEnable_q;
	logic latchedOff_q, alert_q;
	logic [11:0] targetCode, dacRef_q;
	int error_cnt, comparisons, tD, tR, n, t;
	logic okb;
	int lo [5] = '{0, 124, 60, 220, 186};
	int hi [5] = '{0, 136, 70, 240, 200};
	logic [7:0] acts [5] = '{8'h00, 8'h40, 8'h80, 8'h88, 8'h42};

	sts_tbrow_type rows [22] = '{
		'{0, 1, 8'h60, 16'h0000, 0, 16'hF800}, '{0, 1, 8'h61, 16'h0000, 0, 16'hF00C},
		'{0, 1, 8'h62, 16'h0000, 0, 16'hF814}, '{0, 0, 8'h63, 16'h0000, 0, 16'h0080},
		'{1, 1, 8'h60, 16'hF8FF, 0, 16'h0000}, '{0, 1, 8'h60, 16'h0000, 0, 16'hF8FF},
		'{1, 1, 8'h60, 16'hF900, 1, 16'h0000}, '{0, 1, 8'h60, 16'h0000, 0, 16'hF8FF},
		'{1, 1, 8'h61, 16'hF07F, 0, 16'h0000}, '{1, 1, 8'h61, 16'hF080, 1, 16'h0000},
		'{1, 1, 8'h61, 16'hF7FF, 1, 16'h0000}, '{1, 1, 8'h62, 16'hF8FE, 0, 16'h0000},
		'{1, 1, 8'h62, 16'hF8FF, 1, 16'h0000}, '{1, 0, 8'h63, 16'h00C0, 1, 16'h0000},
		'{1, 1, 8'h63, 16'h0080, 1, 16'h0000}, '{0, 0, 8'h63, 16'h0000, 0, 16'h0080},
		'{1, 0, 8'h60, 16'h0002, 1, 16'h0000}, '{1, 1, 8'h60, 16'h0802, 1, 16'h0000},
		'{1, 1, 8'h55, 16'h0000, 1, 16'h0000}, '{0, 0, 8'h7E, 16'h0000, 0, 16'h0080},
		'{1, 0, 8'h03, 16'h0000, 0, 16'h0000}, '{0, 0, 8'h7E, 16'h0000, 0, 16'h0000}};

	sts_sequencer #(.QUARTER_CYCLES(QC), .INIT_CYCLES(IC)) sts_sequencer_i (
		.mclk(mclk), .rst_n(rst_n), .lnkClk(lnkClk), .lnkRst_n(lnkRst_n),
		.lnkReqValid(lnkReqValid), .lnkReq(lnkReq), .lnkBusy_q(lnkBusy_q),
		.lnkDone_q(lnkDone_q), .lnkResp_q(lnkResp_q), .startIn(startIn),
		.above85In(above85In), .targetCode(targetCode), .outputEnable_q(outputEnable_q),
		.rampActive_q(rampActive_q), .uvCheckEnable_q(uvCheckEnable_q), .dacRef_q(dacRef_q),
		.latchedOff_q(latchedOff_q), .alert_q(alert_q));

	sts_host_model sts_host_model_i (
		.lnkClk(lnkClk), .lnkRst_n(lnkRst_n), .lnkReqValid(lnkReqValid), .lnkReq(lnkReq),
		.lnkBusy_q(lnkBusy_q), .lnkDone_q(lnkDone_q), .lnkResp_q(lnkResp_q));

	always #2 mclk = ~mclk;

	// odd start offset keeps the two clocks out of phase
	initial
	begin
		lnkClk = 1'b0;
		#5;
		forever #32 lnkClk = ~lnkClk;
	end

	// sampled off the launching edge so the outputs have settled
	always @(negedge mclk)
		if (rst_n && rampActive_q === 1'b1 && uvCheckEnable_q !== 1'b0)
		begin
			error_cnt++;
			$display("mismatch uv check during ramp expected 0 seen %b", uvCheckEnable_q);
		end

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic acc(input sts_tbrow_type r);
		sts_lresp_type rs;
		logic ok;
		sts_host_model_i.xfer(r.wr, r.wd, r.cmd, r.data, rs, ok);
		if (!ok)
		begin
			$display("mismatch link answer expected done seen none");
			error_cnt++;
			summarize();
		end
		chk("invalid flag", {15'h0, r.inv}, {15'h0, rs.invalid});
		if (!r.wr)
			chk("read data", r.rd, rs.rdData);
	endtask

	// tD: start to ramp, tR: ramp length, both in core cycles
	task automatic launch(input logic hit);
		startIn = 1'b0;
		above85In = 1'b0;
		repeat (6) @(negedge mclk);
		startIn = 1'b1;
		tD = 0;
		while (rampActive_q !== 1'b1 && tD < 2000)
		begin
			@(negedge mclk);
			tD++;
		end
		above85In = hit;
		tR = 0;
		while (rampActive_q === 1'b1 && tR < 2000)
		begin
			@(negedge mclk);
			tR++;
		end
		if (tD >= 2000 || tR >= 2000)
		begin
			$display("mismatch start sequence expected ramp seen timeout");
			error_cnt++;
			summarize();
		end
	endtask

	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		lnkRst_n = 1'b0;
		startIn = 1'b0;
		above85In = 1'b0;
		targetCode = 12'h00A;
		error_cnt = 0;
		comparisons = 0;
		// one link edge resets the link side; the core reset is held for three link edges, the link reset for four
		repeat (3) @(negedge lnkClk);
		chk("outputs in reset", 16'h0000, {11'h0, outputEnable_q, rampActive_q,
			uvCheckEnable_q, latchedOff_q, alert_q});
		chk("reference in reset", 16'h0000, {4'h0, dacRef_q});
		@(negedge mclk);
		rst_n = 1'b1;
		@(negedge lnkClk);
		lnkRst_n = 1'b1;
		foreach (rows[i])
			acc(rows[i]);
		acc('{1, 1, 8'h60, 16'hF9FF, 1, 16'h0000});
		acc('{1, 1, 8'h62, 16'h007F, 0, 16'h0000});
		acc('{1, 1, 8'h62, 16'h0080, 1, 16'h0000});
		repeat (10) @(negedge mclk);
		chk("alert raised", 16'h0001, {15'h0, alert_q});
		acc('{1, 0, 8'h03, 16'h0000, 0, 16'h0000});
		repeat (10) @(negedge mclk);
		chk("alert cleared", 16'h0000, {15'h0, alert_q});
		acc('{1, 1, 8'h60, 16'hF802, 0, 16'h0000});
		acc('{1, 1, 8'h61, 16'hF001, 0, 16'h0000});
		acc('{1, 1, 8'h62, 16'hF800, 0, 16'h0000});
		launch(1'b0);
		chk("delay window", 16'h0001, {15'h0, tD >= IC + 4 * QC && tD <= IC + 4 * QC + 8});
		chk("short ramp", 16'h0001, {15'h0, tR >= 2 * QC && tR <= 2 * QC + 2});
		repeat (2) @(negedge mclk);
		chk("regulate flags", 16'h0003, {14'h0, outputEnable_q, uvCheckEnable_q});
		chk("final reference", {4'h0, targetCode}, {4'h0, dacRef_q});
		repeat (300) @(negedge mclk);
		chk("timeout disabled", 16'h0000, {14'h0, latchedOff_q, alert_q});
		acc('{1, 1, 8'h60, 16'hF800, 0, 16'h0000});
		launch(1'b0);
		chk("minimum delay", 16'h0001, {15'h0, tD >= IC && tD <= IC + 8});
		acc('{1, 1, 8'h62, 16'hF802, 0, 16'h0000});
		acc('{1, 1, 8'h61, 16'hF002, 0, 16'h0000});
		acc('{1, 1, 8'h60, 16'hF802, 0, 16'h0000});
		for (int k = 0; k < 5; k++)
		begin
			acc('{1, 0, 8'h03, 16'h0000, 0, 16'h0000});
			acc('{1, 0, 8'h63, {8'h00, acts[k]}, 0, 16'h0000});
			launch(1'b0);
			n = 0;
			while (latchedOff_q !== 1'b1 && n < 300)
			begin
				@(negedge mclk);
				n++;
			end
			t = tR + n;
			okb = (k == 0) ? (n == 300) : (t >= lo[k] && t <= hi[k]);
			chk("latch-off timing", 16'h0001, {15'h0, okb});
			acc('{0, 0, 8'h7A, 16'h0000, 0, 16'h0004});
			acc('{0, 1, 8'h79, 16'h0000, 0, 16'h8001});
			acc('{0, 0, 8'h78, 16'h0000, 0, 16'h0001});
			chk("alert on timeout", 16'h0001, {15'h0, alert_q});
		end
		acc('{1, 0, 8'h03, 16'h0000, 0, 16'h0000});
		acc('{1, 0, 8'h63, 16'h0080, 0, 16'h0000});
		launch(1'b1);
		// a later dip must not revive a timeout that stopped at the 85 percent point
		above85In = 1'b0;
		repeat (200) @(negedge mclk);
		chk("good start", 16'h0000, {14'h0, latchedOff_q, alert_q});
		summarize();
	end
endmodule

// ===== rtl/sts_sequencer.sv
// startup timing sequencer: turn-on delay, soft-start ramp, startup timeout and response
// assumes the PMBus framing logic hands over decoded transactions on lnkClk
module sts_sequencer
	import sts_pkg::*;
#(
	parameter int QUARTER_CYCLES = QUARTER_MS_CYCLES,
	parameter int INIT_CYCLES = INIT_CYCLES_MIN
)
(
	// core clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// link side transactions
	input wire logic lnkClk,
	input wire logic lnkRst_n,
	input wire logic lnkReqValid,
	input wire sts_lreq_type lnkReq,
	output logic lnkBusy_q,
	output logic lnkDone_q,
	output sts_lresp_type lnkResp_q,
	// converter pins and loop
	input wire logic startIn,
	input wire logic above85In,
	input wire logic [11:0] targetCode,
	output logic outputEnable_q,
	output logic rampActive_q,
	output logic uvCheckEnable_q,
	output logic [11:0] dacRef_q,
	output logic latchedOff_q,
	output logic alert_q
);

	int unsigned phaseCnt_q, tmoCnt_q, waitCnt_q, acc_q;
	sts_state_type state_q, stateD;
	logic [15:0] delayWord_q, riseWord_q, tmoWord_q;
	logic [7:0] actionByte_q;
	logic [7:0] statByte_q, statVout_q, statCml_q;
	logic [15:0] statWord;
	logic [2:0] retryCnt_q;
	logic tmoRun_q, waitRun_q, tmoHit, shutReq;
	logic startS1_q, startS2_q, aboveS1_q, aboveS2_q;
	logic reqTgl_q, reqS1_q, reqS2_q, reqS3_q, ackTgl_q, ackS1_q, ackS2_q, ackS3_q;
	sts_lreq_type lnkHold_q;
	sts_lresp_type respHold_q;
	logic reqNew, setInvalid, clearReq;
	logic [13:0] delayQ, riseQ, tmoQ, wrQ;
	logic [12:0] delayEff, riseEff, tmoEff;
	int unsigned delayCycles, riseCycles, tmoCycles, waitCycles, hiccupCycles;
	logic [1:0] actSel;
	logic [2:0] actRetry, actWait;

	// linear word to quarter milliseconds, bit 13 marks a usable encoding
	function automatic logic [13:0] toQuarter(input logic [15:0] w);
		logic [12:0] m;
		m = {2'b00, w[MAN_HI:0]};
		toQuarter = '0;
		if (!w[MAN_HI])
		begin
			case (w[EXP_HI:EXP_LO])
				EXP_QUARTER: toQuarter = {1'b1, m};
				EXP_HALF: toQuarter = {1'b1, m << 1};
				EXP_UNIT: toQuarter = {1'b1, m << 2};
				default: toQuarter = '0;
			endcase
		end
	endfunction

	// link domain: capture one transaction and hold it until the core answers
	always_ff @(posedge lnkClk)
	begin
		if (!lnkRst_n)
		begin
			lnkBusy_q <= 1'b0;
			lnkDone_q <= 1'b0;
			lnkResp_q <= '0;
			lnkHold_q <= '0;
			reqTgl_q <= 1'b0;
		end
		else
		begin
			lnkDone_q <= 1'b0;
			if (lnkReqValid && !lnkBusy_q)
			begin
				lnkHold_q <= lnkReq;
				reqTgl_q <= ~reqTgl_q;
				lnkBusy_q <= 1'b1;
			end
			else if (lnkBusy_q && (ackS2_q != ackS3_q))
			begin
				lnkBusy_q <= 1'b0;
				lnkDone_q <= 1'b1;
				lnkResp_q <= respHold_q;
			end
		end
	end

	always_ff @(posedge lnkClk)
	begin
		if (!lnkRst_n)
		begin
			ackS1_q <= 1'b0;
			ackS2_q <= 1'b0;
			ackS3_q <= 1'b0;
		end
		else
		begin
			ackS1_q <= ackTgl_q;
			ackS2_q <= ackS1_q;
			ackS3_q <= ackS2_q;
		end
	end

	// core side synchronisers; the held request is stable while the toggle settles
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			{reqS1_q, reqS2_q, reqS3_q} <= 3'h0;
			{startS1_q, startS2_q, aboveS1_q, aboveS2_q} <= 4'h0;
		end
		else
		begin
			reqS1_q <= reqTgl_q;
			reqS2_q <= reqS1_q;
			reqS3_q <= reqS2_q;
			startS1_q <= startIn;
			startS2_q <= startS1_q;
			aboveS1_q <= above85In;
			aboveS2_q <= aboveS1_q;
		end
	end

	assign reqNew = reqS2_q != reqS3_q;
	assign wrQ = toQuarter(lnkHold_q.data);
	assign statWord = {statVout_q != 8'h00, 7'h00, statByte_q};

	// register access: size, range and encoding checks before anything is stored
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			delayWord_q <= DELAY_RST;
			riseWord_q <= RISE_RST;
			tmoWord_q <= TMO_LIMIT_RST;
			actionByte_q <= TMO_ACTION_RST;
			respHold_q <= '0;
			ackTgl_q <= 1'b0;
			setInvalid <= 1'b0;
			clearReq <= 1'b0;
		end
		else
		begin
			setInvalid <= 1'b0;
			clearReq <= 1'b0;
			if (reqNew)
			begin
				ackTgl_q <= ~ackTgl_q;
				respHold_q <= '0;
				case (lnkHold_q.cmd)
					CMD_DELAY, CMD_RISE, CMD_TMO_LIMIT:
					begin
						if (!lnkHold_q.word)
						begin
							respHold_q.invalid <= 1'b1;
							setInvalid <= 1'b1;
						end
						else if (!lnkHold_q.write)
							respHold_q.rdData <= (lnkHold_q.cmd == CMD_DELAY) ? delayWord_q :
								(lnkHold_q.cmd == CMD_RISE) ? riseWord_q : tmoWord_q;
						else if (lnkHold_q.cmd == CMD_DELAY && wrQ[13] && wrQ[12:0] <= DELAY_MAX_Q)
							delayWord_q <= lnkHold_q.data;
						else if (lnkHold_q.cmd == CMD_RISE && wrQ[13] && wrQ[12:0] <= RISE_MAX_Q)
							riseWord_q <= lnkHold_q.data;
						else if (lnkHold_q.cmd == CMD_TMO_LIMIT && wrQ[13] && wrQ[12:0] <= TMO_MAX_Q)
							tmoWord_q <= lnkHold_q.data;
						else
						begin
							respHold_q.invalid <= 1'b1;
							setInvalid <= 1'b1;
						end
					end
					CMD_TMO_ACTION:
					begin
						if (lnkHold_q.word)
						begin
							respHold_q.invalid <= 1'b1;
							setInvalid <= 1'b1;
						end
						else if (!lnkHold_q.write)
							respHold_q.rdData <= {8'h00, actionByte_q};
						else if (lnkHold_q.data[ACT_SEL_HI:ACT_SEL_LO] == 2'h3 || lnkHold_q.data[15:8] != 8'h00)
						begin
							respHold_q.invalid <= 1'b1;
							setInvalid <= 1'b1;
						end
						else
							actionByte_q <= lnkHold_q.data[7:0];
					end
					CMD_STAT_BYTE: respHold_q.rdData <= {8'h00, statByte_q};
					CMD_STAT_WORD: respHold_q.rdData <= statWord;
					CMD_STAT_VOUT: respHold_q.rdData <= {8'h00, statVout_q};
					CMD_STAT_CML: respHold_q.rdData <= {8'h00, statCml_q};
					CMD_CLEAR: clearReq <= lnkHold_q.write;
					default:
					begin
						respHold_q.invalid <= 1'b1;
						setInvalid <= 1'b1;
					end
				endcase
			end
		end
	end

	// effective timings; a delay or limit off the half-millisecond grid rounds to it
	assign delayQ = toQuarter(delayWord_q);
	assign riseQ = toQuarter(riseWord_q);
	assign tmoQ = toQuarter(tmoWord_q);
	assign delayEff = (delayQ[12:0] + 13'h001) & ~13'h001;
	assign tmoEff = (tmoQ[12:0] + 13'h001) & ~13'h001;
	assign riseEff = (riseQ[12:0] < RISE_MIN_Q) ? RISE_MIN_Q : riseQ[12:0];
	assign actSel = actionByte_q[ACT_SEL_HI:ACT_SEL_LO];
	assign actRetry = actionByte_q[ACT_RTY_HI:ACT_RTY_LO];
	assign actWait = actionByte_q[ACT_WAIT_HI:0];
	assign delayCycles = 32'(delayEff) * 32'(QUARTER_CYCLES);
	assign riseCycles = 32'(riseEff) * 32'(QUARTER_CYCLES);
	assign tmoCycles = 32'(tmoEff) * 32'(QUARTER_CYCLES);
	// code 0 waits 1 ms like code 1; hiccup scales the rise time likewise
	assign waitCycles = 32'((actWait == 3'h0) ? 3'h1 : actWait) * 32'(4 * QUARTER_CYCLES);
	assign hiccupCycles = 32'((actWait == 3'h0) ? 3'h1 : actWait) * riseCycles;

	// shutdown decision: immediate, or after the wait if the output is still short
	assign shutReq = (tmoHit && actSel == ACT_IMMEDIATE) ||
		(waitRun_q && waitCnt_q == waitCycles - 1 && !aboveS2_q);

	always_comb
	begin
		stateD = state_q;
		case (state_q)
			ST_IDLE: if (startS2_q) stateD = ST_INIT;
			ST_INIT: if (phaseCnt_q == 32'(INIT_CYCLES) - 1) stateD = ST_DELAY;
			ST_DELAY: if (phaseCnt_q >= delayCycles) stateD = ST_RAMP;
			ST_RAMP:
			begin
				if (shutReq)
					stateD = ST_HICCUP;
				else if (phaseCnt_q == riseCycles - 1)
					stateD = ST_REGULATE;
			end
			ST_REGULATE: if (shutReq) stateD = ST_HICCUP;
			ST_HICCUP: if (phaseCnt_q >= hiccupCycles) stateD = ST_DELAY;
			ST_LATCHOFF: stateD = ST_LATCHOFF;
			default: stateD = ST_IDLE;
		endcase
		// retry budget spent turns a shutdown into latch-off
		if (stateD == ST_HICCUP && state_q != ST_HICCUP &&
			(actRetry == RETRY_LATCH || (actRetry != RETRY_FOREVER && retryCnt_q == actRetry)))
			stateD = ST_LATCHOFF;
		if (!startS2_q)
			stateD = ST_IDLE;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_q <= ST_IDLE;
			phaseCnt_q <= 0;
		end
		else
		begin
			state_q <= stateD;
			phaseCnt_q <= (stateD != state_q) ? 0 : phaseCnt_q + 1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			retryCnt_q <= 3'h0;
		else if (state_q == ST_IDLE || (tmoRun_q && aboveS2_q))
			retryCnt_q <= 3'h0;
		else if (stateD == ST_HICCUP && state_q != ST_HICCUP && retryCnt_q != RETRY_FOREVER)
			retryCnt_q <= retryCnt_q + 3'h1;
	end

	// reference ramp: accumulate target per cycle, step once per rise-time worth
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			dacRef_q <= 12'h000;
			acc_q <= 0;
		end
		else if (stateD == ST_RAMP && state_q != ST_RAMP)
		begin
			dacRef_q <= 12'h000;
			acc_q <= 0;
		end
		else if (state_q == ST_RAMP && stateD == ST_REGULATE)
			dacRef_q <= targetCode;
		else if (state_q == ST_RAMP)
		begin
			// target below the rise count keeps this to one step per cycle
			if (acc_q + 32'(targetCode) >= riseCycles)
			begin
				dacRef_q <= dacRef_q + 12'h001;
				acc_q <= acc_q + 32'(targetCode) - riseCycles;
			end
			else
				acc_q <= acc_q + 32'(targetCode);
		end
		else if (state_q == ST_REGULATE)
			dacRef_q <= targetCode;
		else
			dacRef_q <= 12'h000;
	end

	// startup timeout runs from ramp entry until the 85 percent point
	assign tmoHit = tmoRun_q && !aboveS2_q && tmoCnt_q == tmoCycles - 1;

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			tmoRun_q <= 1'b0;
			tmoCnt_q <= 0;
			waitRun_q <= 1'b0;
			waitCnt_q <= 0;
		end
		else
		begin
			if (stateD == ST_RAMP && state_q == ST_DELAY)
			begin
				tmoRun_q <= tmoEff != 13'h000;
				tmoCnt_q <= 0;
			end
			else if (stateD != ST_RAMP && stateD != ST_REGULATE)
				tmoRun_q <= 1'b0;
			else if (tmoRun_q && (aboveS2_q || tmoHit))
				tmoRun_q <= 1'b0;
			else if (tmoRun_q)
				tmoCnt_q <= tmoCnt_q + 1;
			if (tmoHit && actSel == ACT_DELAYED)
			begin
				waitRun_q <= 1'b1;
				waitCnt_q <= 0;
			end
			else if (stateD != ST_RAMP && stateD != ST_REGULATE)
				waitRun_q <= 1'b0;
			else if (waitRun_q && (aboveS2_q || waitCnt_q == waitCycles - 1))
				waitRun_q <= 1'b0;
			else if (waitRun_q)
				waitCnt_q <= waitCnt_q + 1;
		end
	end

	// status flags: a new event outranks a clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			statByte_q <= 8'h00;
			statVout_q <= 8'h00;
			statCml_q <= 8'h00;
		end
		else
		begin
			statVout_q <= (clearReq ? 8'h00 : statVout_q) | (tmoHit ? 8'(1 << STV_TMO) : 8'h00);
			statCml_q <= (clearReq ? 8'h00 : statCml_q) | (setInvalid ? 8'(1 << CML_INVALID) : 8'h00);
			statByte_q <= (clearReq ? 8'h00 : statByte_q) |
				((tmoHit || setInvalid) ? 8'(1 << STB_NONE_ABOVE) : 8'h00);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			outputEnable_q <= 1'b0;
			rampActive_q <= 1'b0;
			uvCheckEnable_q <= 1'b0;
			latchedOff_q <= 1'b0;
			alert_q <= 1'b0;
		end
		else
		begin
			outputEnable_q <= state_q == ST_RAMP || state_q == ST_REGULATE;
			rampActive_q <= state_q == ST_RAMP;
			uvCheckEnable_q <= state_q == ST_REGULATE;
			latchedOff_q <= state_q == ST_LATCHOFF;
			alert_q <= statByte_q != 8'h00;
		end
	end

	// checks
	int unsigned rampLen_q;
	always_ff @(posedge mclk)
		rampLen_q <= (state_q == ST_RAMP) ? rampLen_q + 1 : 0;

	a_ramp_floor: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == ST_RAMP && stateD == ST_REGULATE) |-> rampLen_q + 1 >= 2 * QUARTER_CYCLES)
		else $error("ramp shorter than half a millisecond");
	a_uv_after_ramp: assert property (@(posedge mclk) disable iff (!rst_n)
		uvCheckEnable_q |-> !rampActive_q && ($past(rampActive_q) || $past(uvCheckEnable_q)))
		else $error("undervoltage check enabled outside regulation");
	a_init_length: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == ST_DELAY && $past(state_q) == ST_INIT) |-> $past(phaseCnt_q) == INIT_CYCLES - 1)
		else $error("initialisation delay not honoured");
	a_delay_length: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == ST_DELAY && stateD == ST_RAMP) |-> phaseCnt_q >= delayCycles)
		else $error("ramp started before the turn-on delay ended");
	a_zero_limit: assert property (@(posedge mclk) disable iff (!rst_n)
		(tmoEff == 13'h000 && $stable(tmoEff)) |-> !tmoHit)
		else $error("timeout fired while disabled");
	a_fault_flags: assert property (@(posedge mclk) disable iff (!rst_n)
		tmoHit |=> statVout_q[STV_TMO] && statByte_q[STB_NONE_ABOVE] && statWord[STW_VOUT] ##1 alert_q)
		else $error("timeout fault did not flag and alert");
	a_invalid_kept: assert property (@(posedge mclk) disable iff (!rst_n)
		setInvalid |-> $stable(delayWord_q) && $stable(riseWord_q) && $stable(tmoWord_q) && $stable(actionByte_q))
		else $error("refused write changed a register");
	a_immediate_off: assert property (@(posedge mclk) disable iff (!rst_n)
		(tmoHit && actSel == ACT_IMMEDIATE && startS2_q) |-> ##2 !outputEnable_q)
		else $error("immediate response left the output on");
	a_latch_nocode: assert property (@(posedge mclk) disable iff (!rst_n)
		(shutReq && actRetry == RETRY_LATCH && startS2_q) |=> state_q == ST_LATCHOFF)
		else $error("zero retry code did not latch off");
	a_ramp_target: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_q == ST_REGULATE && $past(state_q) == ST_RAMP) |-> dacRef_q == $past(targetCode))
		else $error("reference not at target after the ramp");

	c_regulation: cover property (@(posedge mclk) disable iff (!rst_n)
		state_q == ST_RAMP ##1 state_q == ST_REGULATE);
	c_timeout: cover property (@(posedge mclk) disable iff (!rst_n) tmoHit);
	c_hiccup_retry: cover property (@(posedge mclk) disable iff (!rst_n)
		state_q == ST_HICCUP ##1 state_q == ST_DELAY);
	c_invalid_write: cover property (@(posedge mclk) disable iff (!rst_n) setInvalid);

endmodule
